// ===== fsp_pkg.sv
// Purpose: constants, input slots and sequencer states shared by the
//          fault-protection sequencer and its qualification timer.
// Assumes: 10 MHz system clock; one microsecond time base.
// Notes:   long counts are in time-base ticks, not clock cycles.
//
// Contract
// - thermal fault: both gates low, both goods low, termination blocks off, no discharge
// - supply above lockout and shutdown_n high: enable internal reference
// - soft-start begins only after reference_valid rises
// - low-side gate held low from reset until switching begins
// - overvoltage with protection selected: latch, goods low, low-side gate high
// - latched overvoltage: termination blocks off, both discharge switches on
// - overvoltage latch clears only by supply cycle or shutdown toggle; the code clears it on toggle or RST, not when lockout drops
// - protection deselected: overvoltage never latched, regulation continues
// - protection deselected: main good still drops on overvoltage
// - protection deselected: discharge switches stay off through shutdown
// - undervoltage over 200 us: latch, goods low, soft-shutdown pulsing low side
// - high-side gate off throughout fault soft-shutdown
// - fault soft-shutdown end: both gates low, discharge on only with protection selected
// - undervoltage and window latches clear only by supply cycle or toggle; the code clears them on toggle or RST, not when lockout drops
// - window violation over 5 ms: latch, goods low, soft-shutdown
// - thermal trip: latch, goods low, shut down
// - thermal restart only by toggle or reset after cooling reported; RST clears the latch without checking cooling
// - soft-shutdown ramps reference to zero over 2.8 ms first
// - window violation drops termination good at once
package fsp_pkg;

	// ----------------------------------------------------------------
	// time base
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 100;
	localparam int TICK_PERIOD_NS = 1000;
	localparam int TICK_DIV = TICK_PERIOD_NS / CLK_PERIOD_NS;
	localparam int TICK_W = 4;
	localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_DIV - 1);
	localparam int US_PER_TICK = TICK_PERIOD_NS / 1000;

	// ----------------------------------------------------------------
	// qualification and ramp times
	// ----------------------------------------------------------------
	localparam int TMR_W = 16;
	localparam int UV_QUAL_US = 200;
	localparam int TERM_QUAL_MS = 5;
	localparam int SOFT_STOP_US = 2800;
	localparam int SOFT_START_US = 1400;
	localparam int UV_QUAL_TICKS_DEF = UV_QUAL_US / US_PER_TICK;
	localparam int TERM_QUAL_TICKS_DEF = TERM_QUAL_MS * 1000 / US_PER_TICK;
	localparam int SOFT_STOP_TICKS_DEF = SOFT_STOP_US / US_PER_TICK;
	localparam int SOFT_START_TICKS_DEF = SOFT_START_US / US_PER_TICK;

	// ----------------------------------------------------------------
	// synchronised input slots
	// ----------------------------------------------------------------
	localparam int IN_OV = 0;
	localparam int IN_UV = 1;
	localparam int IN_TERM = 2;
	localparam int IN_THERM = 3;
	localparam int IN_COOL = 4;
	localparam int IN_LOCK = 5;
	localparam int IN_REFERENCE_VALID = 6;
	localparam int IN_SHUTDOWN_N = 7;
	localparam int IN_OVPSEL = 8;
	localparam int IN_PWMH = 9;
	localparam int IN_PWML = 10;
	localparam int IN_COUNT = 11;
	localparam logic [IN_COUNT-1:0] IN_RESET = 11'h000;

	// ----------------------------------------------------------------
	// sequencer states
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_OFF = 3'h0,
		ST_REF_WAIT = 3'h1,
		ST_SOFT_START = 3'h2,
		ST_RUN = 3'h3,
		ST_SOFT_STOP = 3'h4,
		ST_STOPPED = 3'h5,
		ST_OV_TRIP = 3'h6,
		ST_THERMAL_OFF = 3'h7
	} fsp_state_t;

endpackage

// ===== fsp_timer.sv
// Purpose: tick-driven qualification / duration counter.
// Assumes: tick is a one-cycle enable from the time-base divider.
// Notes:   count and expiry drop to zero as soon as run falls.
module fsp_timer
	import fsp_pkg::*;
#(
	parameter int WIDTH = TMR_W
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic tick,
	input wire logic run,
	input wire logic [WIDTH-1:0] terminal,
	output logic expired
);

	logic [WIDTH-1:0] count;
	logic [WIDTH-1:0] next_count;
	logic next_expired;

	// ----------------------------------------------------------------
	// count while running
	// ----------------------------------------------------------------
	always_comb
	begin
		next_count = count;
		next_expired = expired;
		if (!run)
		begin
			next_count = '0;
			next_expired = 1'b0;
		end
		else
		begin
			if (tick && (count < terminal))
				next_count = count + 1'b1;
			next_expired = (next_count >= terminal);
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			count <= '0;
			expired <= 1'b0;
		end
		else
		begin
			count <= next_count;
			expired <= next_expired;
		end
	end

endmodule

// ===== fsp_sequencer.sv
// Purpose: fault latches, qualification and start/stop sequencing
//          for the memory power controller.
// Assumes: comparator flags arrive asynchronously on pins.
// Notes:   RST is the power-on-reset level; outputs are registered.
module fsp_sequencer
	import fsp_pkg::*;
#(
	parameter logic [TMR_W-1:0] UV_QUAL_TICKS = TMR_W'(UV_QUAL_TICKS_DEF),
	parameter logic [TMR_W-1:0] TERM_QUAL_TICKS =
		TMR_W'(TERM_QUAL_TICKS_DEF),
	parameter logic [TMR_W-1:0] SOFT_STOP_TICKS =
		TMR_W'(SOFT_STOP_TICKS_DEF),
	parameter logic [TMR_W-1:0] SOFT_START_TICKS =
		TMR_W'(SOFT_START_TICKS_DEF)
)
(
	input wire logic SYS_CLK,
	input wire logic RST,
	input wire logic OUTPUT_OVER_FLAG,
	input wire logic OUTPUT_UNDER_FLAG,
	input wire logic TERM_WINDOW_FLAG,
	input wire logic THERMAL_TRIP,
	input wire logic THERMAL_COOLED,
	input wire logic SUPPLY_ABOVE_LOCKOUT,
	input wire logic REFERENCE_VALID,
	input wire logic SHUTDOWN_N,
	input wire logic OVERVOLTAGE_PROTECT_SELECT,
	input wire logic PWM_HIGH_REQ,
	input wire logic PWM_LOW_REQ,
	output logic HIGH_SIDE_GATE_CMD,
	output logic LOW_SIDE_GATE_CMD,
	output logic MAIN_RAIL_GOOD,
	output logic TERM_RAIL_GOOD,
	output logic INTERNAL_REF_EN,
	output logic SOFT_START_CMD,
	output logic REF_RAMP_DOWN,
	output logic TERMINATION_REGULATOR_EN,
	output logic TERMINATION_REFERENCE_BUFFER_EN,
	output logic SENSE_NEGATIVE_NODE_DISCHARGE_EN,
	output logic TERMINATION_DISCHARGE_EN,
	output logic OV_FAULT_LATCHED,
	output logic UV_FAULT_LATCHED,
	output logic TERM_FAULT_LATCHED,
	output logic THERMAL_FAULT_LATCHED
);

	// ----------------------------------------------------------------
	// input synchronisers and time base
	// ----------------------------------------------------------------
	logic [IN_COUNT-1:0] raw_in;
	logic [IN_COUNT-1:0] sync1;
	logic [IN_COUNT-1:0] sync2;
	logic [IN_COUNT-1:0] sync3;
	logic [IN_COUNT-1:0] stable;
	logic [IN_COUNT-1:0] next_stable;
	logic shutdown_n_prev;
	logic [TICK_W-1:0] tick_cnt;
	logic [TICK_W-1:0] next_tick_cnt;
	logic tick;
	logic next_tick;

	assign raw_in[IN_OV] = OUTPUT_OVER_FLAG;
	assign raw_in[IN_UV] = OUTPUT_UNDER_FLAG;
	assign raw_in[IN_TERM] = TERM_WINDOW_FLAG;
	assign raw_in[IN_THERM] = THERMAL_TRIP;
	assign raw_in[IN_COOL] = THERMAL_COOLED;
	assign raw_in[IN_LOCK] = SUPPLY_ABOVE_LOCKOUT;
	assign raw_in[IN_REFERENCE_VALID] = REFERENCE_VALID;
	assign raw_in[IN_SHUTDOWN_N] = SHUTDOWN_N;
	assign raw_in[IN_OVPSEL] = OVERVOLTAGE_PROTECT_SELECT;
	assign raw_in[IN_PWMH] = PWM_HIGH_REQ;
	assign raw_in[IN_PWML] = PWM_LOW_REQ;

	always_comb
	begin
		next_stable = stable;
		for (int i = 0; i < IN_COUNT; i++)
			if (sync2[i] == sync3[i])
				next_stable[i] = sync3[i];
		next_tick = (tick_cnt == TICK_LAST);
		if (tick_cnt == TICK_LAST)
			next_tick_cnt = '0;
		else
			next_tick_cnt = tick_cnt + 1'b1;
	end

	always_ff @(posedge SYS_CLK)
	begin
		if (RST)
		begin
			sync1 <= IN_RESET;
			sync2 <= IN_RESET;
			sync3 <= IN_RESET;
			stable <= IN_RESET;
			shutdown_n_prev <= 1'b0;
			tick_cnt <= '0;
			tick <= 1'b0;
		end
		else
		begin
			sync1 <= raw_in;
			sync2 <= sync1;
			sync3 <= sync2;
			stable <= next_stable;
			shutdown_n_prev <= stable[IN_SHUTDOWN_N];
			tick_cnt <= next_tick_cnt;
			tick <= next_tick;
		end
	end

	// ----------------------------------------------------------------
	// qualified views of the inputs
	// ----------------------------------------------------------------
	logic ov_flag;
	logic uv_flag;
	logic term_flag;
	logic therm_flag;
	logic cooled;
	logic lock_ok;
	logic ref_ok;
	logic shutdown_n_n;
	logic ovp_sel;
	logic pwm_h;
	logic pwm_l;
	logic shutdown_n_rise;

	assign ov_flag = stable[IN_OV];
	assign uv_flag = stable[IN_UV];
	assign term_flag = stable[IN_TERM];
	assign therm_flag = stable[IN_THERM];
	assign cooled = stable[IN_COOL];
	assign lock_ok = stable[IN_LOCK];
	assign ref_ok = stable[IN_REFERENCE_VALID];
	assign shutdown_n_n = stable[IN_SHUTDOWN_N];
	assign ovp_sel = stable[IN_OVPSEL];
	assign pwm_h = stable[IN_PWMH];
	assign pwm_l = stable[IN_PWML];
	assign shutdown_n_rise = shutdown_n_n && !shutdown_n_prev;

	// ----------------------------------------------------------------
	// timers
	// ----------------------------------------------------------------
	fsp_state_t state;
	fsp_state_t next_state;
	logic uv_expired;
	logic term_expired;
	logic stop_done;
	logic start_done;
	logic uv_run;
	logic term_run;

	assign uv_run = uv_flag && (state == ST_RUN);
	assign term_run = term_flag && (state == ST_RUN);

	fsp_timer #(.WIDTH(TMR_W)) u_uv_timer (
		.clk(SYS_CLK),
		.rst(RST),
		.tick(tick),
		.run(uv_run),
		.terminal(UV_QUAL_TICKS),
		.expired(uv_expired)
	);

	fsp_timer #(.WIDTH(TMR_W)) u_term_timer (
		.clk(SYS_CLK),
		.rst(RST),
		.tick(tick),
		.run(term_run),
		.terminal(TERM_QUAL_TICKS),
		.expired(term_expired)
	);

	fsp_timer #(.WIDTH(TMR_W)) u_stop_timer (
		.clk(SYS_CLK),
		.rst(RST),
		.tick(tick),
		.run(state == ST_SOFT_STOP),
		.terminal(SOFT_STOP_TICKS),
		.expired(stop_done)
	);

	fsp_timer #(.WIDTH(TMR_W)) u_start_timer (
		.clk(SYS_CLK),
		.rst(RST),
		.tick(tick),
		.run(state == ST_SOFT_START),
		.terminal(SOFT_START_TICKS),
		.expired(start_done)
	);

	// ----------------------------------------------------------------
	// latches, state and outputs: next values
	// ----------------------------------------------------------------
	logic ov_latch;
	logic uv_latch;
	logic term_latch;
	logic therm_latch;
	logic next_ov_latch;
	logic next_uv_latch;
	logic next_term_latch;
	logic next_therm_latch;
	logic switching;
	logic out_fault;
	logic next_dh;
	logic next_dl;
	logic next_main_good;
	logic next_term_good;
	logic next_ref_en;
	logic next_ss;
	logic next_ramp;
	logic next_vtt_en;
	logic next_termination_reference_buffer_en;
	logic next_dis;

	always_comb
	begin
		switching = (state == ST_SOFT_START) || (state == ST_RUN) ||
			(state == ST_SOFT_STOP);
		next_ov_latch = ov_latch;
		next_uv_latch = uv_latch;
		next_term_latch = term_latch;
		next_therm_latch = therm_latch;
		if (shutdown_n_rise)
		begin
			next_ov_latch = 1'b0;
			next_uv_latch = 1'b0;
			next_term_latch = 1'b0;
		end
		if (shutdown_n_rise && cooled && !therm_flag)
			next_therm_latch = 1'b0;
		if (ovp_sel && ov_flag && switching)
			next_ov_latch = 1'b1;
		if (uv_expired)
			next_uv_latch = 1'b1;
		if (term_expired)
			next_term_latch = 1'b1;
		if (therm_flag)
			next_therm_latch = 1'b1;
		out_fault = next_uv_latch || next_term_latch;

		next_state = state;
		case (state)
			ST_OFF:
				if (lock_ok && shutdown_n_n && !out_fault && !next_ov_latch)
					next_state = ST_REF_WAIT;
			ST_REF_WAIT:
				if (!shutdown_n_n)
					next_state = ST_OFF;
				else if (ref_ok)
					next_state = ST_SOFT_START;
			ST_SOFT_START:
				if (!shutdown_n_n || out_fault)
					next_state = ST_SOFT_STOP;
				else if (start_done)
					next_state = ST_RUN;
			ST_RUN:
				if (!shutdown_n_n || out_fault)
					next_state = ST_SOFT_STOP;
			ST_SOFT_STOP:
				if (stop_done)
					next_state = ST_STOPPED;
			ST_STOPPED:
				if (shutdown_n_n && !out_fault)
					next_state = ST_OFF;
			ST_OV_TRIP:
				if (!next_ov_latch)
					next_state = ST_OFF;
			ST_THERMAL_OFF:
				if (!next_therm_latch)
					next_state = ST_OFF;
			default:
				next_state = ST_OFF;
		endcase
		if (next_therm_latch)
			next_state = ST_THERMAL_OFF;
		else if (!lock_ok)
			next_state = ST_OFF;
		else if (next_ov_latch)
			next_state = ST_OV_TRIP;

		next_dh = 1'b0;
		next_dl = 1'b0;
		next_main_good = 1'b0;
		next_term_good = 1'b0;
		next_ref_en = 1'b0;
		next_ss = 1'b0;
		next_ramp = 1'b0;
		next_vtt_en = 1'b0;
		next_termination_reference_buffer_en = 1'b0;
		next_dis = 1'b0;
		case (next_state)
			ST_OFF:
				next_dis = ovp_sel && !lock_ok;
			ST_REF_WAIT:
			begin
				next_ref_en = 1'b1;
				next_dl = 1'b0;
			end
			ST_SOFT_START:
			begin
				next_ref_en = 1'b1;
				next_ss = 1'b1;
				next_vtt_en = 1'b1;
				next_termination_reference_buffer_en = 1'b1;
				next_dh = pwm_h;
				next_dl = pwm_l;
			end
			ST_RUN:
			begin
				next_ref_en = 1'b1;
				next_vtt_en = 1'b1;
				next_termination_reference_buffer_en = 1'b1;
				next_dh = pwm_h;
				next_dl = pwm_l;
				next_main_good = !ov_flag && !uv_flag;
				next_term_good = !term_flag;
			end
			ST_SOFT_STOP:
			begin
				next_ref_en = 1'b1;
				next_ramp = 1'b1;
				next_vtt_en = 1'b1;
				next_termination_reference_buffer_en = 1'b1;
				next_dh = 1'b0;
				next_dl = pwm_l;
			end
			ST_STOPPED:
			begin
				next_dh = 1'b0;
				next_dl = ovp_sel && !out_fault;
				next_dis = ovp_sel;
			end
			ST_OV_TRIP:
			begin
				next_dl = 1'b1;
				next_dis = 1'b1;
			end
			ST_THERMAL_OFF:
				next_dis = 1'b0;
			default:
				next_dis = 1'b0;
		endcase
	end

	// ----------------------------------------------------------------
	// latches, state and outputs: registers
	// ----------------------------------------------------------------
	always_ff @(posedge SYS_CLK)
	begin
		if (RST)
		begin
			state <= ST_OFF;
			ov_latch <= 1'b0;
			uv_latch <= 1'b0;
			term_latch <= 1'b0;
			therm_latch <= 1'b0;
			HIGH_SIDE_GATE_CMD <= 1'b0;
			LOW_SIDE_GATE_CMD <= 1'b0;
			MAIN_RAIL_GOOD <= 1'b0;
			TERM_RAIL_GOOD <= 1'b0;
			INTERNAL_REF_EN <= 1'b0;
			SOFT_START_CMD <= 1'b0;
			REF_RAMP_DOWN <= 1'b0;
			TERMINATION_REGULATOR_EN <= 1'b0;
			TERMINATION_REFERENCE_BUFFER_EN <= 1'b0;
			SENSE_NEGATIVE_NODE_DISCHARGE_EN <= 1'b0;
			TERMINATION_DISCHARGE_EN <= 1'b0;
			OV_FAULT_LATCHED <= 1'b0;
			UV_FAULT_LATCHED <= 1'b0;
			TERM_FAULT_LATCHED <= 1'b0;
			THERMAL_FAULT_LATCHED <= 1'b0;
		end
		else
		begin
			state <= next_state;
			ov_latch <= next_ov_latch;
			uv_latch <= next_uv_latch;
			term_latch <= next_term_latch;
			therm_latch <= next_therm_latch;
			HIGH_SIDE_GATE_CMD <= next_dh;
			LOW_SIDE_GATE_CMD <= next_dl;
			MAIN_RAIL_GOOD <= next_main_good;
			TERM_RAIL_GOOD <= next_term_good;
			INTERNAL_REF_EN <= next_ref_en;
			SOFT_START_CMD <= next_ss;
			REF_RAMP_DOWN <= next_ramp;
			TERMINATION_REGULATOR_EN <= next_vtt_en;
			TERMINATION_REFERENCE_BUFFER_EN <= next_termination_reference_buffer_en;
			SENSE_NEGATIVE_NODE_DISCHARGE_EN <= next_dis;
			TERMINATION_DISCHARGE_EN <= next_dis;
			OV_FAULT_LATCHED <= next_ov_latch;
			UV_FAULT_LATCHED <= next_uv_latch;
			TERM_FAULT_LATCHED <= next_term_latch;
			THERMAL_FAULT_LATCHED <= next_therm_latch;
		end
	end

endmodule

// ===== fsp_checker.sv
// Purpose: pin-level timing and state checks on the sequencer
// Assumes: tick counts handed on from the bound instance
// Notes: sees ports only; bound at the foot of this file
module fsp_checker
	import fsp_pkg::*;
#(
	parameter logic [TMR_W-1:0] UV_QUAL_TICKS = 16'h0003,
	parameter logic [TMR_W-1:0] SOFT_STOP_TICKS = 16'h0008
)
(
	input wire logic SYS_CLK,
	input wire logic RST,
	input wire logic OUTPUT_UNDER_FLAG,
	input wire logic TERM_WINDOW_FLAG,
	input wire logic SUPPLY_ABOVE_LOCKOUT,
	input wire logic REFERENCE_VALID,
	input wire logic OVERVOLTAGE_PROTECT_SELECT,
	input wire logic HIGH_SIDE_GATE_CMD,
	input wire logic LOW_SIDE_GATE_CMD,
	input wire logic MAIN_RAIL_GOOD,
	input wire logic TERM_RAIL_GOOD,
	input wire logic SOFT_START_CMD,
	input wire logic REF_RAMP_DOWN,
	input wire logic TERMINATION_REGULATOR_EN,
	input wire logic SENSE_NEGATIVE_NODE_DISCHARGE_EN,
	input wire logic TERMINATION_DISCHARGE_EN,
	input wire logic OV_FAULT_LATCHED,
	input wire logic UV_FAULT_LATCHED,
	input wire logic TERM_FAULT_LATCHED,
	input wire logic THERMAL_FAULT_LATCHED
);
	// ------------------------------------------------------------
	// helper counters
	// ------------------------------------------------------------
	localparam int UV_MIN = (int'(UV_QUAL_TICKS) - 1) * TICK_DIV;
	localparam int RD_MIN = (int'(SOFT_STOP_TICKS) - 1) * TICK_DIV;
	localparam int RD_MAX = (int'(SOFT_STOP_TICKS) + 1) * TICK_DIV + 1;
	logic [15:0] uv_cnt, next_uv_cnt, rd_cnt, next_rd_cnt;
	logic flt, sd_dis;
	assign flt = UV_FAULT_LATCHED || TERM_FAULT_LATCHED;
	assign sd_dis = SENSE_NEGATIVE_NODE_DISCHARGE_EN;
	always_comb
	begin
		next_uv_cnt = OUTPUT_UNDER_FLAG ? uv_cnt + 16'h0001 : 16'h0000;
		next_rd_cnt = REF_RAMP_DOWN ? rd_cnt + 16'h0001 : 16'h0000;
	end
	always_ff @(posedge SYS_CLK)
	begin
		uv_cnt <= RST ? 16'h0000 : next_uv_cnt;
		rd_cnt <= RST ? 16'h0000 : next_rd_cnt;
	end
	// ------------------------------------------------------------
	// properties
	// ------------------------------------------------------------
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (RST);
	property p_therm;
		THERMAL_FAULT_LATCHED |-> !(HIGH_SIDE_GATE_CMD || LOW_SIDE_GATE_CMD
			|| MAIN_RAIL_GOOD || TERM_RAIL_GOOD || sd_dis
			|| TERMINATION_REGULATOR_EN);
	endproperty
	a_therm: assert property (p_therm) else $error("thermal state");
	property p_ov;
		(SUPPLY_ABOVE_LOCKOUT[*8] ##0 (OV_FAULT_LATCHED
			&& !THERMAL_FAULT_LATCHED)) |-> LOW_SIDE_GATE_CMD
			&& !HIGH_SIDE_GATE_CMD && !MAIN_RAIL_GOOD && !TERM_RAIL_GOOD
			&& !TERMINATION_REGULATOR_EN && sd_dis;
	endproperty
	a_ov: assert property (p_ov) else $error("ov state");
	property p_ovsel;
		$rose(OV_FAULT_LATCHED) |-> $past(OVERVOLTAGE_PROTECT_SELECT, 3);
	endproperty
	a_ovsel: assert property (p_ovsel) else $error("ov unselected");
	property p_dis;
		sd_dis |-> TERMINATION_DISCHARGE_EN && OVERVOLTAGE_PROTECT_SELECT;
	endproperty
	a_dis: assert property (p_dis) else $error("discharge");
	property p_uv;
		$rose(UV_FAULT_LATCHED) |-> ##[0:1] (REF_RAMP_DOWN
			&& !MAIN_RAIL_GOOD && !TERM_RAIL_GOOD);
	endproperty
	a_uv: assert property (p_uv) else $error("uv entry");
	property p_uvq;
		$rose(UV_FAULT_LATCHED) |-> uv_cnt >= UV_MIN;
	endproperty
	a_uvq: assert property (p_uvq) else $error("uv too early");
	property p_hs;
		REF_RAMP_DOWN && flt |-> !HIGH_SIDE_GATE_CMD;
	endproperty
	a_hs: assert property (p_hs) else $error("high side on");
	property p_end;
		$fell(REF_RAMP_DOWN) && flt |-> ##[0:1] (!HIGH_SIDE_GATE_CMD
			&& !LOW_SIDE_GATE_CMD && sd_dis == OVERVOLTAGE_PROTECT_SELECT);
	endproperty
	a_end: assert property (p_end) else $error("stop end");
	property p_ramp;
		$fell(REF_RAMP_DOWN) |-> rd_cnt >= RD_MIN && rd_cnt <= RD_MAX;
	endproperty
	a_ramp: assert property (p_ramp) else $error("ramp length");
	property p_win;
		TERM_WINDOW_FLAG[*7] |-> !TERM_RAIL_GOOD;
	endproperty
	a_win: assert property (p_win) else $error("term good");
	property p_ss;
		$rose(SOFT_START_CMD) |-> $past(REFERENCE_VALID, 4);
	endproperty
	a_ss: assert property (p_ss) else $error("early start");
	property p_rst;
		$fell(RST) |-> (!LOW_SIDE_GATE_CMD && !MAIN_RAIL_GOOD
			&& !TERM_RAIL_GOOD && !OV_FAULT_LATCHED && !flt)[*4];
	endproperty
	a_rst: assert property (p_rst) else $error("reset state");
	c_ov: cover property ($rose(OV_FAULT_LATCHED));
	c_uv: cover property ($rose(UV_FAULT_LATCHED));
	c_term: cover property ($rose(TERM_FAULT_LATCHED));
	c_therm: cover property ($rose(THERMAL_FAULT_LATCHED));
endmodule

bind fsp_sequencer fsp_checker #(.UV_QUAL_TICKS(UV_QUAL_TICKS),
	.SOFT_STOP_TICKS(SOFT_STOP_TICKS)) fsp_checker_inst (.*);

// ===== fsp_partner.sv
// Purpose: reference source and regulation loop beside the sequencer
// Assumes: reference settles a fixed time after enable
// Notes: gate requests never overlap
module fsp_partner
(
	input wire logic clk,
	input wire logic ref_en,
	output logic ref_valid,
	output logic pwm_h,
	output logic pwm_l
);
	logic [4:0] dly = 5'h00;
	logic [2:0] ph = 3'h0;
	always @(posedge clk)
	begin
		dly <= ref_en ? (dly == 5'h1F ? dly : dly + 5'h01) : 5'h00;
		ph <= ph + 3'h1;
	end
	assign ref_valid = (dly == 5'h1F);
	assign pwm_h = (ph < 3'h3);
	assign pwm_l = (ph > 3'h3) && (ph < 3'h7);
endmodule

// ===== tb_top.sv
// Purpose: self-checking bench for the fault sequencer
// Assumes: short tick counts 3, 5, 8 and 6
// Notes: latch events are checked against a queue of expectations
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic SYS_CLK = 1'b0, RST = 1'b1;
	logic OUTPUT_OVER_FLAG, OUTPUT_UNDER_FLAG;
	logic TERM_WINDOW_FLAG, THERMAL_TRIP;
	logic THERMAL_COOLED, SUPPLY_ABOVE_LOCKOUT;
	logic SHUTDOWN_N, OVERVOLTAGE_PROTECT_SELECT;
	logic REFERENCE_VALID, PWM_HIGH_REQ, PWM_LOW_REQ;
	logic HIGH_SIDE_GATE_CMD, LOW_SIDE_GATE_CMD, MAIN_RAIL_GOOD;
	logic TERM_RAIL_GOOD, INTERNAL_REF_EN, SOFT_START_CMD, REF_RAMP_DOWN;
	logic TERMINATION_REGULATOR_EN, TERMINATION_REFERENCE_BUFFER_EN;
	logic SENSE_NEGATIVE_NODE_DISCHARGE_EN, TERMINATION_DISCHARGE_EN;
	logic OV_FAULT_LATCHED, UV_FAULT_LATCHED, TERM_FAULT_LATCHED;
	logic THERMAL_FAULT_LATCHED;
	logic [14:0] o;
	logic [3:0] prev = 4'h0;
	logic [3:0] exp_q[$];
	int fails = 0, n_tests = 0, cyc = 0, n;
	assign o = {HIGH_SIDE_GATE_CMD, LOW_SIDE_GATE_CMD, MAIN_RAIL_GOOD,
		TERM_RAIL_GOOD, INTERNAL_REF_EN, SOFT_START_CMD, REF_RAMP_DOWN,
		TERMINATION_REGULATOR_EN, TERMINATION_REFERENCE_BUFFER_EN,
		SENSE_NEGATIVE_NODE_DISCHARGE_EN, TERMINATION_DISCHARGE_EN,
		OV_FAULT_LATCHED, UV_FAULT_LATCHED, TERM_FAULT_LATCHED,
		THERMAL_FAULT_LATCHED};
	always #50 SYS_CLK = ~SYS_CLK;
	fsp_sequencer #(.UV_QUAL_TICKS(16'h0003), .TERM_QUAL_TICKS(16'h0005),
		.SOFT_STOP_TICKS(16'h0008), .SOFT_START_TICKS(16'h0006))
		fsp_sequencer_inst (.*);
	fsp_partner fsp_partner_inst (.clk(SYS_CLK), .ref_en(INTERNAL_REF_EN),
		.ref_valid(REFERENCE_VALID), .pwm_h(PWM_HIGH_REQ),
		.pwm_l(PWM_LOW_REQ));
	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [14:0] e, input logic [14:0] m);
		n_tests++;
		if ((o & m) !== e)
		begin
			fails++;
			$display("ERROR %0t exp %h got %h", $time, e, o & m);
		end
	endtask
	task automatic chk_lat(input logic [3:0] e, input logic [3:0] g);
		n_tests++;
		if (g !== e)
		begin
			fails++;
			$display("ERROR %0t latch exp %h got %h", $time, e, g);
		end
	endtask
	task automatic cy(input int c);
		repeat (c) @(posedge SYS_CLK);
	endtask
	task automatic wt(input int b, input logic v);
		int k;
		k = 0;
		while (o[b] !== v && k < 3000)
		begin
			@(posedge SYS_CLK);
			k++;
		end
		chk(v ? 15'h7FFF & (15'h0001 << b) : 15'h0000, 15'h0001 << b);
	endtask
	task automatic tog();
		SHUTDOWN_N <= 1'b0;
		cy(20);
		SHUTDOWN_N <= 1'b1;
		cy(20);
	endtask
	task automatic rst_to(input logic sel);
		@(posedge SYS_CLK);
		RST <= 1'b1;
		OVERVOLTAGE_PROTECT_SELECT <= sel;
		OUTPUT_OVER_FLAG <= 1'b0;
		OUTPUT_UNDER_FLAG <= 1'b0;
		TERM_WINDOW_FLAG <= 1'b0;
		THERMAL_TRIP <= 1'b0;
		THERMAL_COOLED <= 1'b0;
		SUPPLY_ABOVE_LOCKOUT <= 1'b1;
		SHUTDOWN_N <= 1'b1;
		cy(2);
		RST <= 1'b0;
	endtask
	task automatic close_out();
		if (exp_q.size() != 0)
			fails++;
		$display("checks %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// ------------------------------------------------------------
	// latch monitor and watchdog
	// ------------------------------------------------------------
	always @(posedge SYS_CLK)
	begin
		if (!RST && (o[3:0] & ~prev) != 4'h0)
		begin
			if (exp_q.size() == 0)
				chk_lat(prev, o[3:0]);
			else
				chk_lat(exp_q.pop_front(), o[3:0]);
		end
		prev = o[3:0];
		cyc++;
		if (cyc == 20000)
		begin
			fails++;
			close_out();
		end
	end
	// ------------------------------------------------------------
	// tests
	// ------------------------------------------------------------
	initial
	begin
		void'($urandom(79));
		rst_to(1'b1);
		wt(12, 1'b1);
		exp_q.push_back(4'h8);
		OUTPUT_OVER_FLAG <= 1'b1;
		wt(3, 1'b1);
		cy(2);
		chk(15'h2030, 15'h78F0);
		OUTPUT_OVER_FLAG <= 1'b0;
		cy(10);
		chk(15'h0008, 15'h0008);
		tog();
		chk(15'h0000, 15'h0008);
		$display("test overvoltage done");
		wt(12, 1'b1);
		repeat (3)
		begin
			n = 5 + int'($urandom % 20);
			TERM_WINDOW_FLAG <= 1'b1;
			cy(n);
			TERM_WINDOW_FLAG <= 1'b0;
			cy(20);
		end
		chk(15'h0000, 15'h0002);
		exp_q.push_back(4'h2);
		TERM_WINDOW_FLAG <= 1'b1;
		cy(10);
		chk(15'h0000, 15'h0802);
		wt(1, 1'b1);
		cy(2);
		wt(8, 1'b0);
		cy(2);
		chk(15'h0030, 15'h6030);
		TERM_WINDOW_FLAG <= 1'b0;
		tog();
		chk(15'h0000, 15'h0002);
		$display("test window done");
		wt(12, 1'b1);
		exp_q.push_back(4'h1);
		THERMAL_TRIP <= 1'b1;
		wt(0, 1'b1);
		cy(2);
		chk(15'h0001, 15'h78F1);
		THERMAL_TRIP <= 1'b0;
		tog();
		chk(15'h0001, 15'h0001);
		THERMAL_COOLED <= 1'b1;
		tog();
		chk(15'h0000, 15'h0001);
		$display("test thermal done");
		rst_to(1'b0);
		wt(12, 1'b1);
		OUTPUT_OVER_FLAG <= 1'b1;
		cy(10);
		chk(15'h0800, 15'h1808);
		OUTPUT_OVER_FLAG <= 1'b0;
		wt(12, 1'b1);
		$display("test unselected done");
		exp_q.push_back(4'h4);
		OUTPUT_UNDER_FLAG <= 1'b1;
		wt(2, 1'b1);
		cy(2);
		wt(8, 1'b0);
		cy(2);
		chk(15'h0000, 15'h6030);
		OUTPUT_UNDER_FLAG <= 1'b0;
		tog();
		chk(15'h0000, 15'h0004);
		$display("test undervoltage done");
		wt(12, 1'b1);
		SUPPLY_ABOVE_LOCKOUT <= 1'b0;
		cy(10);
		chk(15'h0000, 15'h7FF0);
		SUPPLY_ABOVE_LOCKOUT <= 1'b1;
		wt(10, 1'b1);
		wt(9, 1'b1);
		wt(12, 1'b1);
		$display("test lockout done");
		close_out();
	end
endmodule
